// ==== sim/ebp_ext_dev.sv ====
/*
  far side model: one external memory word and an outside bus master.
  assumes it sees resolved pin levels; strobes idle high by pull-up.
*/
`default_nettype none
module ebp_ext_dev (
  // resolved pins
  input  wire logic        clk,
  input  wire logic [15:0] ad,
  input  wire logic        wr0_n,
  input  wire logic        wr1_n,
  input  wire logic        rd_n,
  // outside master and data it puts on the lines
  input  wire logic        want_bus,
  output logic             hold_request_n = 1'b1,
  output logic [15:0]      dev_data = 16'h0000
);
  logic [15:0] mem_reg = 16'h0000;
  // byte writes; lines show the inverted last value unless read
  always @(posedge clk) begin
    if (!wr0_n) mem_reg[7:0] <= ad[7:0];
    if (!wr1_n) mem_reg[15:8] <= ad[15:8];
    dev_data <= rd_n ? ~ad : mem_reg;
    hold_request_n <= !want_bus;
  end
endmodule
`default_nettype wire

// ==== sim/ebp_top_properties.sv ====
/*
  checker: pin level and drive assertions for the bus pin controller.
  assumes it is bound into ebp_top and sees only that module's ports.
*/
`default_nettype none
module ebp_top_properties #(
  parameter int AD_W = 16
) (
  // clock, reset and core side
  input wire logic               clk,
  input wire logic               rst_n,
  input wire ebp_pkg::ebp_mode_t core_mode,
  input wire ebp_pkg::ebp_req_t  core_req,
  input wire logic               hold_granted,
  input wire logic               wait_active,
  // pins
  input wire logic [AD_W-1:0]    muxed_addr_data_lines_o,
  input wire logic [AD_W-1:0]    muxed_addr_data_lines_oe,
  input wire logic               chip_select_zero_o,
  input wire logic               chip_select_zero_oe,
  input wire logic               chip_select_one_o,
  input wire logic               chip_select_one_oe,
  input wire logic               low_byte_write_strobe_n_o,
  input wire logic               low_byte_write_strobe_n_oe,
  input wire logic               high_byte_write_strobe_n_o,
  input wire logic               high_byte_write_strobe_n_oe,
  input wire logic               read_strobe_n_o,
  input wire logic               read_strobe_n_oe,
  input wire logic               address_latch_strobe_o,
  input wire logic               address_latch_strobe_oe,
  input wire logic               bus_clock_output_o,
  input wire logic               bus_clock_output_oe,
  input wire logic               hold_request_n_i,
  input wire logic               hold_acknowledge_n_o,
  input wire logic               hold_acknowledge_n_oe
);
  logic [7:0]      st;
  logic [3:0]      cs;
  logic [AD_W-1:0] aoe;
  logic            nrm;
  logic            lowp;
  logic            quiet;
  // grouped pins and mode shorthands
  assign st = {low_byte_write_strobe_n_o, low_byte_write_strobe_n_oe, high_byte_write_strobe_n_o,
    high_byte_write_strobe_n_oe, read_strobe_n_o, read_strobe_n_oe, address_latch_strobe_o,
    address_latch_strobe_oe};
  assign cs = {chip_select_zero_o, chip_select_zero_oe, chip_select_one_o, chip_select_one_oe};
  assign aoe = muxed_addr_data_lines_oe;
  assign nrm = core_mode == ebp_pkg::EBP_NORMAL;
  assign lowp = core_mode inside {ebp_pkg::EBP_HALT, ebp_pkg::EBP_IDLE, ebp_pkg::EBP_STOP};
  assign quiet = &({st[7], st[5], st[3], st[1]} | ~{st[6], st[4], st[2], st[0]});
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // multi-step behaviours
  sequence s_halt2;
    core_mode == ebp_pkg::EBP_HALT ##1 core_mode == ebp_pkg::EBP_HALT;
  endsequence
  sequence s_hold_req;
    (core_mode == ebp_pkg::EBP_HOLD && !hold_request_n_i) [*3];
  endsequence
  chk_intmem_quiet: assert property (
    nrm && core_req.kind == ebp_pkg::EBP_ACC_INTMEM |=> aoe == '0 && quiet) else $error("intmem");
  chk_periph_addr: assert property (
    nrm && core_req.kind == ebp_pkg::EBP_ACC_PERIPH |=> quiet && ($past(core_req.addr_phase) ?
    (&aoe && muxed_addr_data_lines_o == $past(core_req.addr)) : aoe == '0)) else $error("periph");
  chk_reset_float: assert property (
    core_mode == ebp_pkg::EBP_RESET |=> ~|{aoe, cs[2], cs[0], st[6], st[4], st[2], st[0],
    bus_clock_output_oe, hold_acknowledge_n_oe}) else $error("reset drive");
  chk_lowpower_high: assert property (lowp |=> &st && &cs) else $error("low power levels");
  chk_clk_low: assert property (
    core_mode inside {ebp_pkg::EBP_IDLE, ebp_pkg::EBP_STOP} |=> bus_clock_output_oe &&
    !bus_clock_output_o && aoe == '0 && hold_acknowledge_n_oe && hold_acknowledge_n_o)
    else $error("idle stop levels");
  chk_clk_runs: assert property (
    s_halt2 |=> bus_clock_output_oe && bus_clock_output_o != $past(bus_clock_output_o))
    else $error("clock stopped in halt");
  chk_hold_float: assert property (
    core_mode == ebp_pkg::EBP_HOLD |=> ~|{aoe, cs[2], cs[0], st[6], st[4], st[2], st[0]}
    && bus_clock_output_oe) else $error("hold drive");
  chk_hold_ack: assert property (
    s_hold_req |=> hold_acknowledge_n_oe && !hold_acknowledge_n_o) else $error("no hold ack");
  chk_idle_held: assert property (
    nrm && core_req.kind == ebp_pkg::EBP_ACC_EXT && core_req.bus_idle |=> &st
    && $stable(muxed_addr_data_lines_o) && $stable(cs)) else $error("bus idle levels");
  chk_byte_strobes: assert property (
    nrm && core_req.kind == ebp_pkg::EBP_ACC_EXT && core_req.write && !core_req.addr_phase
    && !core_req.bus_idle |=> st[7] == !$past(core_req.byte_en[0])
    && st[5] == !$past(core_req.byte_en[1])) else $error("byte strobes");
  chk_wait_refused: assert property (!nrm |=> !wait_active) else $error("wait seen");
endmodule
bind ebp_top ebp_top_properties #(.AD_W(AD_W)) ebp_top_properties_i (.*);
`default_nettype wire

// ==== sim/test_ebp_top.sv ====
/*
  self-checking bench for the bus pin controller: queued pin expectations.
  assumes the checker is bound and ebp_ext_dev sits on the pins.
*/
`default_nettype none
module test_ebp_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int due; logic [47:0] msk; logic [47:0] val;} ebp_note_t;
  localparam logic [47:0] ADOE = 48'hffff_0000_0000;
  localparam logic [47:0] AD = 48'h0000_ffff_0000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic want_bus = 1'b0;
  logic wait_n = 1'b1;
  logic [1:0] wait_hist = 2'b00;
  ebp_pkg::ebp_mode_t core_mode = ebp_pkg::EBP_RESET;
  ebp_pkg::ebp_req_t core_req = '0;
  logic hold_granted, wait_active, hold_request_n;
  logic [15:0] rdata, ad_o, ad_oe, ad_in, dev_data, pins;
  int cyc = 0;
  int errors = 0;
  int total_checks = 0;
  ebp_note_t notes[$];
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // wire level of the shared lines
  assign ad_in = (ad_oe & ad_o) | (~ad_oe & dev_data);
  ebp_top ebp_top_i (.clk(clk), .rst_n(rst_n), .core_mode(core_mode), .core_req(core_req),
    .hold_granted(hold_granted), .wait_active(wait_active), .rdata(rdata),
    .muxed_addr_data_lines_i(ad_in), .muxed_addr_data_lines_o(ad_o),
    .muxed_addr_data_lines_oe(ad_oe), .chip_select_zero_o(pins[15]),
    .chip_select_zero_oe(pins[14]), .chip_select_one_o(pins[13]), .chip_select_one_oe(pins[12]),
    .low_byte_write_strobe_n_o(pins[11]), .low_byte_write_strobe_n_oe(pins[10]),
    .high_byte_write_strobe_n_o(pins[9]), .high_byte_write_strobe_n_oe(pins[8]),
    .read_strobe_n_o(pins[7]), .read_strobe_n_oe(pins[6]), .address_latch_strobe_o(pins[5]),
    .address_latch_strobe_oe(pins[4]), .bus_clock_output_o(pins[3]),
    .bus_clock_output_oe(pins[2]), .wait_n_i(wait_n), .hold_request_n_i(hold_request_n),
    .hold_acknowledge_n_o(pins[1]), .hold_acknowledge_n_oe(pins[0]));
  ebp_ext_dev ebp_ext_dev_i (.clk(clk), .ad(ad_in), .wr0_n(pins[11] | ~pins[10]),
    .wr1_n(pins[9] | ~pins[8]), .rd_n(pins[7] | ~pins[6]), .want_bus(want_bus),
    .hold_request_n(hold_request_n), .dev_data(dev_data));
  // one cycle of core stimulus, noting the pin state expected after it
  task automatic step(ebp_pkg::ebp_mode_t m, logic [47:0] msk, logic [47:0] val);
    core_mode = m;
    // wait level two steps back is what the synchroniser hands over now
    wait_hist = {wait_hist[0], wait_n};
    wait_n = 1'($urandom);
    notes.push_back('{cyc + 1, msk, val});
    @(posedge clk);
    #1;
  endtask
  task automatic set_req(ebp_pkg::ebp_acc_t k, logic ph, logic wr, logic [1:0] be, logic idl);
    core_req.kind = k;
    core_req.addr_phase = ph;
    core_req.write = wr;
    core_req.byte_en = be;
    core_req.bus_idle = idl;
  endtask
  task automatic summarize();
    $display("checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // oldest note against the settled pins
  always @(posedge clk) begin
    #2;
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      total_checks++;
      if ((({ad_oe, ad_o, pins} ^ notes[0].val) & notes[0].msk) !== 48'h0000_0000_0000) begin
        errors++;
        $display("[ERR] %0t pin state differs, cycle %0d", $time, notes[0].due);
      end
      void'(notes.pop_front());
    end
  end
  // watchdog
  initial begin
    #20000;
    errors++;
    summarize();
  end
  // main sequence
  initial begin
    void'($urandom(49166));
    #1;
    repeat (4) step(ebp_pkg::EBP_RESET, '1, '0);
    rst_n = 1'b1;
    step(ebp_pkg::EBP_RESET, '1, '0);
    core_req.addr = 16'($urandom);
    core_req.wdata = 16'($urandom);
    core_req.cs_sel = 2'($urandom);
    set_req(ebp_pkg::EBP_ACC_INTMEM, 1'b1, 1'b1, 2'h3, 1'b0);
    step(ebp_pkg::EBP_NORMAL, ADOE, '0);
    set_req(ebp_pkg::EBP_ACC_PERIPH, 1'b1, 1'b0, 2'h0, 1'b0);
    step(ebp_pkg::EBP_NORMAL, ADOE | AD, {16'hffff, core_req.addr, 16'h0000});
    set_req(ebp_pkg::EBP_ACC_PERIPH, 1'b0, 1'b0, 2'h0, 1'b0);
    step(ebp_pkg::EBP_NORMAL, ADOE, '0);
    for (int b = 1; b < 4; b++) begin
      set_req(ebp_pkg::EBP_ACC_EXT, 1'b1, 1'b1, 2'(b), 1'b0);
      step(ebp_pkg::EBP_NORMAL, ADOE | AD | 48'h0030, {16'hffff, core_req.addr, 16'h0010});
      set_req(ebp_pkg::EBP_ACC_EXT, 1'b0, 1'b1, 2'(b), 1'b0);
      step(ebp_pkg::EBP_NORMAL, ADOE | AD | 48'h0f00, {16'hffff, core_req.wdata, 4'h0,
        ~b[0], 1'b1, ~b[1], 1'b1, 8'h00});
      set_req(ebp_pkg::EBP_ACC_EXT, 1'b0, 1'b0, 2'(b), 1'b1);
      step(ebp_pkg::EBP_NORMAL, AD | 48'h0ff0, {16'h0000, core_req.wdata, 16'h0ff0});
    end
    set_req(ebp_pkg::EBP_ACC_EXT, 1'b0, 1'b0, 2'h3, 1'b0);
    // read: model answers one cycle late, third capture sees the stored word
    repeat (3) begin
      step(ebp_pkg::EBP_NORMAL, ADOE | 48'h00c0, 48'h0040);
      total_checks++;
      if (wait_active !== ~wait_hist[1]) begin
        errors++;
        $display("[ERR] %0t wait flag differs from synced pin", $time);
      end
    end
    total_checks++;
    if (rdata !== core_req.wdata) begin
      errors++;
      $display("[ERR] %0t read data differs from written word", $time);
    end
    repeat (2) step(ebp_pkg::EBP_HALT, 48'hfff0, 48'hfff0);
    step(ebp_pkg::EBP_IDLE, ADOE | 48'hffff, 48'hfff7);
    step(ebp_pkg::EBP_STOP, ADOE | 48'hffff, 48'hfff7);
    want_bus = 1'b1;
    repeat (3) begin
      step(ebp_pkg::EBP_NORMAL, '0, '0);
      total_checks++;
      if (hold_granted !== 1'b0) begin
        errors++;
        $display("[ERR] %0t hold granted outside hold mode", $time);
      end
    end
    repeat (3) step(ebp_pkg::EBP_HOLD, ADOE | 48'h5554, 48'h0004);
    step(ebp_pkg::EBP_HOLD, ADOE | 48'h5557, 48'h0005);
    total_checks++;
    if (hold_granted !== 1'b1) begin
      errors++;
      $display("[ERR] %0t hold not granted", $time);
    end
    want_bus = 1'b0;
    repeat (4) step(ebp_pkg::EBP_NORMAL, '0, '0);
    step(ebp_pkg::EBP_RESET, '1, '0);
    repeat (2) @(posedge clk);
    summarize();
  end
endmodule
`default_nettype wire

// ==== src/ebp_defs.svh ====
/*
  constants for the external bus pin state controller.
  assumes inclusion by bare name from design files only.
*/
`ifndef EBP_DEFS_SVH
`define EBP_DEFS_SVH
`define EBP_AD_W       16
`define EBP_ADDR_ZERO  16'h0000
`define EBP_HIGH       1'b1
`define EBP_LOW        1'b0
`define EBP_CNT_ZERO   4'h0
`define EBP_CNT_ONE    4'h1
`endif

// ==== src/ebp_pkg.sv ====
/*
  types for the external bus pin state controller.
  assumes ebp_defs.svh is on the include path.
*/
`include "ebp_defs.svh"
`default_nettype none
package ebp_pkg;
  // operating status of the chip
  typedef enum logic [2:0] {
    EBP_RESET  = 3'h0,
    EBP_NORMAL = 3'h1,
    EBP_HALT   = 3'h3,
    EBP_STOP   = 3'h2,
    EBP_IDLE   = 3'h6,
    EBP_HOLD   = 3'h7
  } ebp_mode_t;

  // kind of access the core is making
  typedef enum logic [1:0] {
    EBP_ACC_NONE  = 2'h0,
    EBP_ACC_INTMEM = 2'h1,
    EBP_ACC_PERIPH = 2'h3,
    EBP_ACC_EXT   = 2'h2
  } ebp_acc_t;

  // core request towards the bus
  typedef struct packed {
    ebp_acc_t                 kind;
    logic [`EBP_AD_W-1:0]     addr;
    logic [`EBP_AD_W-1:0]     wdata;
    logic                     write;
    logic [1:0]               byte_en;
    logic [1:0]               cs_sel;
    logic                     addr_phase;
    logic                     bus_idle;
  } ebp_req_t;

  // one driven pin: value and enable
  typedef struct packed {
    logic o;
    logic oe;
  } ebp_pin_t;

  // all outgoing pins
  typedef struct packed {
    logic [`EBP_AD_W-1:0] ad_o;
    logic [`EBP_AD_W-1:0] ad_oe;
    ebp_pin_t             cs0;
    ebp_pin_t             cs1;
    ebp_pin_t             wr0;
    ebp_pin_t             wr1;
    ebp_pin_t             rd;
    ebp_pin_t             address_latch_strobe;
    ebp_pin_t             clk;
    ebp_pin_t             hlda;
  } ebp_pins_t;
endpackage
`default_nettype wire

// ==== src/ebp_sync.sv ====
/*
  two-stage synchroniser, parameterised width.
  assumes the input is asynchronous to clk.
*/
`default_nettype none
module ebp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  initial begin
    if (W < 1) $error("width must be at least one");
  end

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ==== src/ebp_top.sv ====
/*
  external bus pin state controller: sets level and drive of the
  multiplexed bus pins for each access kind and operating state.
  assumes mode and request come from core logic on clk; wait and hold
  request arrive from pins and are synchronised here.
*/
`include "ebp_defs.svh"
`default_nettype none
module ebp_top #(
  parameter int AD_W = `EBP_AD_W
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // core side
  input  wire ebp_pkg::ebp_mode_t       core_mode,
  input  wire ebp_pkg::ebp_req_t        core_req,
  output logic                          hold_granted,
  output logic                          wait_active,
  output logic [AD_W-1:0]               rdata,
  // pins: muxed address/data
  input  wire logic [AD_W-1:0]          muxed_addr_data_lines_i,
  output logic [AD_W-1:0]               muxed_addr_data_lines_o,
  output logic [AD_W-1:0]               muxed_addr_data_lines_oe,
  // pins: chip selects and strobes
  output logic                          chip_select_zero_o,
  output logic                          chip_select_zero_oe,
  output logic                          chip_select_one_o,
  output logic                          chip_select_one_oe,
  output logic                          low_byte_write_strobe_n_o,
  output logic                          low_byte_write_strobe_n_oe,
  output logic                          high_byte_write_strobe_n_o,
  output logic                          high_byte_write_strobe_n_oe,
  output logic                          read_strobe_n_o,
  output logic                          read_strobe_n_oe,
  output logic                          address_latch_strobe_o,
  output logic                          address_latch_strobe_oe,
  // pins: clock, wait, hold
  output logic                          bus_clock_output_o,
  output logic                          bus_clock_output_oe,
  input  wire logic                     wait_n_i,
  input  wire logic                     hold_request_n_i,
  output logic                          hold_acknowledge_n_o,
  output logic                          hold_acknowledge_n_oe
);
  typedef struct packed {
    ebp_pkg::ebp_pins_t    pins;
    logic [AD_W-1:0]       held_ad;
    logic                  held_cs0;
    logic                  held_cs1;
    logic                  clk_tgl;
    logic                  hold_req;
    logic                  granted;
    logic                  waiting;
    logic [AD_W-1:0]       rdata;
  } ebp_state_t;

  ebp_state_t state_reg;
  ebp_state_t state_next;
  logic       wait_s;
  logic       hreq_s;

  initial begin
    if (AD_W != `EBP_AD_W) $error("bus width must match pin count");
  end

  // wait and hold request pin inputs pass two flip-flops
  ebp_sync #(.W(2)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({~wait_n_i, ~hold_request_n_i}),
    .q     ({wait_s, hreq_s})
  );

  // next pin levels from mode and access kind
  always_comb begin
    state_next = state_reg;
    state_next.clk_tgl = ~state_reg.clk_tgl;
    // default every pin released
    state_next.pins = '0;
    case (core_mode)
      ebp_pkg::EBP_RESET: begin
        state_next = '0;
      end
      ebp_pkg::EBP_HALT: begin
        state_next.pins.ad_o  = state_reg.pins.ad_o;        // undefined
        state_next.pins.ad_oe = {AD_W{`EBP_HIGH}};
        state_next.pins.cs0   = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.cs1   = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.wr0   = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.wr1   = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.rd    = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.address_latch_strobe  = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.clk   = '{state_next.clk_tgl, `EBP_HIGH};
        state_next.hold_req   = hreq_s;                     // sampled here
        state_next.pins.hlda  = '{`EBP_HIGH, `EBP_HIGH};
        state_next.granted    = `EBP_LOW;
      end
      ebp_pkg::EBP_IDLE, ebp_pkg::EBP_STOP: begin
        state_next.pins.cs0   = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.cs1   = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.wr0   = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.wr1   = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.rd    = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.address_latch_strobe  = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.clk   = '{`EBP_LOW, `EBP_HIGH};     // held low
        state_next.pins.hlda  = '{`EBP_HIGH, `EBP_HIGH};
        state_next.granted    = `EBP_LOW;
        state_next.waiting    = `EBP_LOW;                   // wait unsampled
      end
      ebp_pkg::EBP_HOLD: begin
        // bus lines released to the outside master
        state_next.pins.clk   = '{state_next.clk_tgl, `EBP_HIGH};
        state_next.hold_req   = hreq_s;
        state_next.pins.hlda  = '{~state_next.hold_req, `EBP_HIGH}; // low while held
        state_next.granted    = state_next.hold_req;
        state_next.waiting    = `EBP_LOW;
      end
      default: begin
        // normal operation
        state_next.pins.clk   = '{state_next.clk_tgl, `EBP_HIGH};
        state_next.pins.hlda  = '{`EBP_HIGH, `EBP_HIGH};
        state_next.granted    = `EBP_LOW;
        state_next.pins.cs0   = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.cs1   = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.wr0   = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.wr1   = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.rd    = '{`EBP_HIGH, `EBP_HIGH};
        state_next.pins.address_latch_strobe  = '{`EBP_HIGH, `EBP_HIGH};
        state_next.waiting    = `EBP_LOW;
        if (core_req.bus_idle) begin
          // idle state after the third bus state
          state_next.pins.ad_o  = state_reg.held_ad;
          state_next.pins.ad_oe = {AD_W{`EBP_HIGH}};
          state_next.pins.cs0   = '{state_reg.held_cs0, `EBP_HIGH};
          state_next.pins.cs1   = '{state_reg.held_cs1, `EBP_HIGH};
        end else if (core_req.kind == ebp_pkg::EBP_ACC_INTMEM) begin
          // address keeps stale value, data undriven
          state_next.pins.ad_o  = state_reg.pins.ad_o;
          state_next.pins.ad_oe = {AD_W{`EBP_LOW}};
        end else if (core_req.kind == ebp_pkg::EBP_ACC_PERIPH) begin
          // peripheral address shown, data floats, strobes stay high
          state_next.pins.ad_o  = core_req.addr;
          state_next.pins.ad_oe = core_req.addr_phase ? {AD_W{`EBP_HIGH}}
                                                      : {AD_W{`EBP_LOW}};
        end else if (core_req.kind == ebp_pkg::EBP_ACC_EXT) begin
          state_next.pins.cs0 = '{~core_req.cs_sel[0], `EBP_HIGH};
          state_next.pins.cs1 = '{~core_req.cs_sel[1], `EBP_HIGH};
          state_next.held_cs0 = ~core_req.cs_sel[0];
          state_next.held_cs1 = ~core_req.cs_sel[1];
          state_next.waiting  = wait_s;                     // sampled in external access cycles
          if (core_req.addr_phase) begin
            state_next.pins.ad_o  = core_req.addr;
            state_next.pins.ad_oe = {AD_W{`EBP_HIGH}};
            state_next.pins.address_latch_strobe  = '{`EBP_LOW, `EBP_HIGH};
          end else if (core_req.write) begin
            state_next.pins.ad_o  = core_req.wdata;
            state_next.pins.ad_oe = {AD_W{`EBP_HIGH}};
            state_next.pins.wr0   = '{~core_req.byte_en[0], `EBP_HIGH}; // low byte
            state_next.pins.wr1   = '{~core_req.byte_en[1], `EBP_HIGH}; // high byte
          end else begin
            state_next.pins.rd = '{`EBP_LOW, `EBP_HIGH};
            state_next.rdata   = muxed_addr_data_lines_i;
          end
          state_next.held_ad = state_next.pins.ad_o;
        end
      end
    endcase
  end

  // register the whole state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;                                      // all pins float
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  assign muxed_addr_data_lines_o     = state_reg.pins.ad_o;
  assign muxed_addr_data_lines_oe    = state_reg.pins.ad_oe;
  assign chip_select_zero_o          = state_reg.pins.cs0.o;
  assign chip_select_zero_oe         = state_reg.pins.cs0.oe;
  assign chip_select_one_o           = state_reg.pins.cs1.o;
  assign chip_select_one_oe          = state_reg.pins.cs1.oe;
  assign low_byte_write_strobe_n_o   = state_reg.pins.wr0.o;
  assign low_byte_write_strobe_n_oe  = state_reg.pins.wr0.oe;
  assign high_byte_write_strobe_n_o  = state_reg.pins.wr1.o;
  assign high_byte_write_strobe_n_oe = state_reg.pins.wr1.oe;
  assign read_strobe_n_o             = state_reg.pins.rd.o;
  assign read_strobe_n_oe            = state_reg.pins.rd.oe;
  assign address_latch_strobe_o      = state_reg.pins.address_latch_strobe.o;
  assign address_latch_strobe_oe     = state_reg.pins.address_latch_strobe.oe;
  assign bus_clock_output_o          = state_reg.pins.clk.o;
  assign bus_clock_output_oe         = state_reg.pins.clk.oe;
  assign hold_acknowledge_n_o        = state_reg.pins.hlda.o;
  assign hold_acknowledge_n_oe       = state_reg.pins.hlda.oe;
  assign hold_granted                = state_reg.granted;
  assign wait_active                 = state_reg.waiting;
  assign rdata                       = state_reg.rdata;
endmodule
`default_nettype wire
